// ==== src/rwsc_pkg.sv ====
// shared constants and carrier types for the reset, watchdog and suspend controller
package rwsc_pkg;
    // i/o register addresses
    localparam logic [7:0] ADDR_WDOG_CLEAR = 8'h26;
    localparam logic [7:0] ADDR_CLK_CFG = 8'hF8;
    localparam logic [7:0] ADDR_STATUS = 8'hFF;
    // processor status and control fields
    localparam int ST_RUN_BIT = 0;
    localparam int ST_IES_BIT = 2;
    localparam int ST_SUSP_BIT = 3;
    localparam int ST_LVBOR_BIT = 4;
    localparam int ST_WDR_BIT = 6;
    localparam logic [7:0] ST_CAUSE_MASK = 8'h50;
    localparam logic [7:0] ST_RUN_MASK = 8'h01;
    localparam logic [7:0] ST_LVBOR_MASK = 8'h10;
    localparam logic [7:0] ST_WDR_MASK = 8'h40;
    localparam logic [7:0] STATUS_RST = 8'h11;
    // clock configuration fields
    localparam int CFG_EXTOSC_BIT = 0;
    localparam int CFG_LVRDIS_BIT = 3;
    localparam int CFG_RESDLY_BIT = 7;
    localparam logic [7:0] CLK_CFG_RST = 8'h00;
    // reset values of execution state
    localparam logic [15:0] FETCH_ADDR_RST = 16'h0000;
    localparam logic [7:0] STACK_PTR_RST = 8'h00;
    // timing, times in microseconds, counts in 100 MHz cycles
    localparam int CLK_MHZ = 100;
    localparam int CNT_W = 24;
    localparam int SETTLE_US = 16000;
    localparam int WDOG_PERIOD_US = 8000;
    localparam int WDR_HOLD_US = 2000;
    localparam int EXT_FAST_US = 128;
    localparam int EXT_SLOW_US = 4000;
    localparam int INT_RESUME_US = 8;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int WDOG_PERIOD_CYC = WDOG_PERIOD_US * CLK_MHZ;
    localparam int WDR_HOLD_CYC = WDR_HOLD_US * CLK_MHZ;
    localparam int EXT_FAST_CYC = EXT_FAST_US * CLK_MHZ;
    localparam int EXT_SLOW_CYC = EXT_SLOW_US * CLK_MHZ;
    localparam int INT_RESUME_CYC = INT_RESUME_US * CLK_MHZ;

    typedef enum logic [6:0] {
        ST_HOLD = 7'b0000001,
        ST_SETTLE = 7'b0000010,
        ST_WDRH = 7'b0000100,
        ST_RUN = 7'b0001000,
        ST_SUSP = 7'b0010000,
        ST_OSCWAIT = 7'b0100000,
        ST_RESDLY = 7'b1000000
    } rwsc_state_t;

    typedef struct packed {
        logic hold;
        logic chip_reset;
        logic pc_load;
        logic pc_push;
        logic ptr_clear;
        logic int_disable;
        logic usb_disable;
        logic pins_hiz;
        logic int_defer;
    } rwsc_core_ctl_t;

    typedef struct packed {
        logic int_osc_on;
        logic ext_osc_on;
        logic ext_mode;
        logic lvr_on;
        logic bor_on;
        logic wdog_on;
    } rwsc_clk_ctl_t;
endpackage

// ==== src/rwsc_wdog.sv ====
// watchdog counter that pulses on roll-over
`timescale 1ns/1ps
module rwsc_wdog
    import rwsc_pkg::*;
#(
    parameter logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(WDOG_PERIOD_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic clear,
    output logic roll
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic at_end;

    assign at_end = (cnt_ff == PERIOD_CYC - CNT_W'(1));
    assign roll = run & ~clear & at_end;
    assign nxt_cnt = (clear | ~run | at_end) ? '0 : cnt_ff + CNT_W'(1);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // rwsc_wdog

// ==== src/rwsc_ctrl.sv ====
// reset, watchdog and suspend controller top
// Operation
// - low-voltage, brown-out, watchdog resets; cause kept in status bits 4 and 6
// - execution restarts at address 0x0000 without pushing pc or flags
// - reset clears all registers except the status and control register
// - reset floats gpio, usb and pull-up regulator pins
// - reset disables interrupts and usb until firmware re-enables them
// - low-voltage or brown-out reset selects internal clock then waits settle time
// - watchdog reset keeps clock mode, no settle wait, clears external-oscillator bit
// - reset sets program and data stack pointers to 0x00
// - power-up enables low-voltage reset, starts internal oscillator, settles, then runs
// - low-voltage reset repeats whenever supply drops; bit 3 disables it
// - low-voltage reset off in suspend, back on afterwards if it was enabled
// - brown-out acts when low-voltage reset is off; shared flag set to one
// - brown-out holds reset until above threshold, then settles, starts at zero
// - any write to 0x26 restarts watchdog; roll-over resets and sets bit 6
// - watchdog reset held 2 to 4 ms, then execution at zero
// - suspend stops logic, oscillators and timers except wake sources
// - wake on enabled gpio, wake-up timer, spi slave interrupt or low data-minus
// - on wake restart clocks, wait stability plus mode-selected delay
// - any enabled pending interrupt wakes if the run bit is set, interrupt-enable-sense bit ignored
// - suspend entered even with wake already present, then normal resume
// - after wake the next instruction runs before any interrupt service
// - clock config bit 3 set disables low-voltage reset, clear enables it
// - external-clock resume waits 128 us or 4 ms by resume-delay bit
`timescale 1ns/1ps
module rwsc_ctrl
    import rwsc_pkg::*;
#(
    parameter logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYC),
    parameter logic [CNT_W-1:0] WDOG_CNT = CNT_W'(WDOG_PERIOD_CYC),
    parameter logic [CNT_W-1:0] WDR_HOLD_CNT = CNT_W'(WDR_HOLD_CYC),
    parameter logic [CNT_W-1:0] EXT_FAST_CNT = CNT_W'(EXT_FAST_CYC),
    parameter logic [CNT_W-1:0] EXT_SLOW_CNT = CNT_W'(EXT_SLOW_CYC)
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    input wire logic VCC_BELOW_LVT,
    input wire logic VCC_BELOW_BOR,
    input wire logic DATA_MINUS_LINE,
    input wire logic OSC_STABLE,
    input wire logic WAKE_INT_PEND,
    input wire logic INSN_DONE,
    output rwsc_core_ctl_t CORE_CTL,
    output rwsc_clk_ctl_t CLK_CTL,
    output logic [15:0] FETCH_ADDR,
    output logic [7:0] PROG_STACK_PTR,
    output logic [7:0] DATA_STACK_PTR
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] sync_raw;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    assign sync_raw = {OSC_STABLE, DATA_MINUS_LINE, VCC_BELOW_BOR, VCC_BELOW_LVT};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (RST) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else if (CE) begin
                    sync1_ff[gi] <= sync_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    logic lv_s;
    logic bor_s;
    logic dm_s;
    logic osc_s;
    assign lv_s = sync2_ff[0];
    assign bor_s = sync2_ff[1];
    assign dm_s = sync2_ff[2];
    assign osc_s = sync2_ff[3];

    ////////////////////////////////////////////////////////////////////////////
    // state and registers
    rwsc_state_t st_ff;
    rwsc_state_t nxt_st;
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic [7:0] clk_cfg_ff;
    logic [7:0] nxt_clk_cfg;
    logic ext_mode_ff;
    logic nxt_ext_mode;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic int_defer_ff;
    logic pc_load_ff;
    logic [7:0] rdata_ff;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    logic running;
    logic suspended;
    logic wr_ok;
    logic wr_status;
    logic wr_cfg;
    logic wr_wdog;
    logic wr_susp;
    logic wr_ext_on;
    logic lvr_on;
    logic trip;
    logic wd_roll;
    logic wake;
    logic [CNT_W-1:0] resume_cnt;

    assign running = (st_ff == ST_RUN);
    assign suspended = (st_ff == ST_SUSP);
    assign wr_ok = IO_WR & running;
    assign wr_status = wr_ok & hit(IO_ADDR, ADDR_STATUS);
    assign wr_cfg = wr_ok & hit(IO_ADDR, ADDR_CLK_CFG);
    assign wr_wdog = wr_ok & hit(IO_ADDR, ADDR_WDOG_CLEAR);
    assign wr_susp = wr_status & IO_WDATA[ST_SUSP_BIT];
    assign wr_ext_on = wr_cfg & IO_WDATA[CFG_EXTOSC_BIT] & ~ext_mode_ff;
    // low-voltage monitor follows the disable bit and is dropped in suspend
    assign lvr_on = ~clk_cfg_ff[CFG_LVRDIS_BIT] & ~suspended;
    // brown-out monitor always watches, covering every case with lvr off
    assign trip = (lvr_on & lv_s) | bor_s;
    // any enabled pending interrupt or low data-minus wakes, run bit required
    assign wake = (WAKE_INT_PEND | ~dm_s) & status_ff[ST_RUN_BIT];
    assign resume_cnt = ext_mode_ff ? (clk_cfg_ff[CFG_RESDLY_BIT] ? EXT_SLOW_CNT : EXT_FAST_CNT)
                                    : CNT_W'(INT_RESUME_CYC);

    rwsc_wdog #(
        .PERIOD_CYC(WDOG_CNT)
    ) u_wdog (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .run(running),
        .clear(wr_wdog),
        .roll(wd_roll)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = (cnt_ff != '0) ? cnt_ff - CNT_W'(1) : cnt_ff;
        nxt_ext_mode = ext_mode_ff;
        case (st_ff)
            ST_HOLD: begin
                if (!lv_s && !bor_s) begin
                    nxt_st = ST_SETTLE;
                    nxt_cnt = SETTLE_CNT - CNT_W'(1);
                end
            end
            ST_SETTLE, ST_WDRH: begin
                if (cnt_ff == '0) begin
                    nxt_st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wd_roll) begin
                    nxt_st = ST_WDRH;
                    nxt_cnt = WDR_HOLD_CNT - CNT_W'(1);
                end else if (wr_susp) begin
                    nxt_st = ST_SUSP;
                end else if (wr_ext_on) begin
                    nxt_st = ST_OSCWAIT;
                    nxt_ext_mode = 1'b1;
                end
            end
            ST_SUSP: begin
                if (wake) begin
                    nxt_st = ST_OSCWAIT;
                    nxt_ext_mode = clk_cfg_ff[CFG_EXTOSC_BIT];
                end
            end
            ST_OSCWAIT: begin
                if (osc_s) begin
                    nxt_st = ST_RESDLY;
                    nxt_cnt = resume_cnt - CNT_W'(1);
                end
            end
            ST_RESDLY: begin
                if (cnt_ff == '0) begin
                    nxt_st = ST_RUN;
                end
            end
            default: begin
                nxt_st = ST_HOLD;
            end
        endcase
        if (trip) begin
            nxt_st = ST_HOLD;
            nxt_ext_mode = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register updates, event sets win over firmware writes
    always_comb begin
        nxt_status = wr_status ? IO_WDATA : status_ff;
        nxt_clk_cfg = wr_cfg ? IO_WDATA : clk_cfg_ff;
        if (trip) begin
            nxt_status = (status_ff & ST_CAUSE_MASK) | ST_LVBOR_MASK | ST_RUN_MASK;
            nxt_clk_cfg = CLK_CFG_RST;
        end else if (running && wd_roll) begin
            nxt_status = (status_ff & ST_CAUSE_MASK) | ST_WDR_MASK | ST_RUN_MASK;
            nxt_clk_cfg = CLK_CFG_RST;
        end else if (nxt_st == ST_RUN && !running) begin
            nxt_status[ST_SUSP_BIT] = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_ff <= ST_HOLD;
            status_ff <= STATUS_RST;
            clk_cfg_ff <= CLK_CFG_RST;
            ext_mode_ff <= 1'b0;
            cnt_ff <= '0;
        end else if (CE) begin
            st_ff <= nxt_st;
            status_ff <= nxt_status;
            clk_cfg_ff <= nxt_clk_cfg;
            ext_mode_ff <= nxt_ext_mode;
            cnt_ff <= nxt_cnt;
        end
    end

    // released from reset or resumed from suspend
    logic rel_reset;
    logic rel_resume;
    assign rel_reset = (nxt_st == ST_RUN) && (st_ff == ST_SETTLE || st_ff == ST_WDRH);
    assign rel_resume = (nxt_st == ST_RUN) && (st_ff == ST_RESDLY);

    always_ff @(posedge CLK) begin
        if (RST) begin
            pc_load_ff <= 1'b0;
            int_defer_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else if (CE) begin
            pc_load_ff <= rel_reset;
            if (rel_resume) begin
                int_defer_ff <= 1'b1;
            end else if (INSN_DONE || !running) begin
                int_defer_ff <= 1'b0;
            end
            rdata_ff <= !IO_RD ? 8'h00 : hit(IO_ADDR, ADDR_STATUS) ? status_ff
                      : hit(IO_ADDR, ADDR_CLK_CFG) ? clk_cfg_ff : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    logic in_reset;
    assign in_reset = (st_ff == ST_HOLD) | (st_ff == ST_SETTLE) | (st_ff == ST_WDRH);

    assign CORE_CTL.hold = ~running;
    assign CORE_CTL.chip_reset = in_reset;
    assign CORE_CTL.pc_load = pc_load_ff;
    assign CORE_CTL.pc_push = 1'b0;
    assign CORE_CTL.ptr_clear = in_reset;
    assign CORE_CTL.int_disable = in_reset;
    assign CORE_CTL.usb_disable = in_reset;
    assign CORE_CTL.pins_hiz = in_reset;
    assign CORE_CTL.int_defer = int_defer_ff;
    assign CLK_CTL.int_osc_on = ~suspended & ~ext_mode_ff;
    assign CLK_CTL.ext_osc_on = ~suspended & ext_mode_ff;
    assign CLK_CTL.ext_mode = ext_mode_ff;
    assign CLK_CTL.lvr_on = lvr_on;
    assign CLK_CTL.bor_on = 1'b1;
    assign CLK_CTL.wdog_on = running;
    assign FETCH_ADDR = FETCH_ADDR_RST;
    assign PROG_STACK_PTR = STACK_PTR_RST;
    assign DATA_STACK_PTR = STACK_PTR_RST;
    assign IO_RDATA = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_cause_lvbor: assert property (@(posedge CLK) disable iff (RST)
        (CE && trip) |=> (status_ff[ST_LVBOR_BIT] && st_ff == ST_HOLD))
        else $error("lv/bor trip did not set flag and hold");
    chk_cause_wdog: assert property (@(posedge CLK) disable iff (RST)
        (CE && running && wd_roll && !trip) |=> (status_ff[ST_WDR_BIT] && st_ff == ST_WDRH))
        else $error("watchdog roll-over did not reset");
    chk_fetch_zero: assert property (@(posedge CLK) disable iff (RST)
        $rose(pc_load_ff) |-> (running && FETCH_ADDR == 16'h0000 && !CORE_CTL.pc_push))
        else $error("restart not at address zero");
    chk_trip_clears: assert property (@(posedge CLK) disable iff (RST)
        (CE && trip) |=> (clk_cfg_ff == 8'h00 && !ext_mode_ff))
        else $error("trip left clock config or mode");
    chk_reset_pins: assert property (@(posedge CLK) disable iff (RST)
        (st_ff == ST_SETTLE) |-> (CORE_CTL.pins_hiz && CORE_CTL.int_disable && CORE_CTL.usb_disable
                                  && CORE_CTL.ptr_clear))
        else $error("reset did not float pins");
    chk_wdr_mode: assert property (@(posedge CLK) disable iff (RST)
        (CE && running && wd_roll && !trip) |=> (ext_mode_ff == $past(ext_mode_ff) && !clk_cfg_ff[0]))
        else $error("watchdog reset changed clock mode");
    chk_susp_entry: assert property (@(posedge CLK) disable iff (RST)
        (CE && wr_susp && !wd_roll && !trip) |=> suspended)
        else $error("suspend write not honoured");
    chk_susp_quiet: assert property (@(posedge CLK) disable iff (RST)
        suspended |-> (!lvr_on && !CLK_CTL.int_osc_on && !CLK_CTL.ext_osc_on && !CLK_CTL.wdog_on))
        else $error("logic left on in suspend");
    chk_susp_gate: assert property (@(posedge CLK) disable iff (RST)
        (CE && suspended && !status_ff[ST_RUN_BIT] && !trip) |=> suspended)
        else $error("resumed without run bit");
    chk_resume_osc: assert property (@(posedge CLK) disable iff (RST)
        (st_ff == ST_OSCWAIT && !osc_s && !trip) |=> (st_ff == ST_OSCWAIT))
        else $error("resumed before oscillator stable");
    chk_int_defer: assert property (@(posedge CLK) disable iff (RST)
        (CE && rel_resume && !trip) |=> (running && int_defer_ff))
        else $error("interrupts not deferred after wake");
endmodule // rwsc_ctrl

// ==== verification/tb_rwsc_ctrl.sv ====
// self-checking testbench for the reset, watchdog and suspend controller
`timescale 1ns/1ps
module tb_rwsc_ctrl
    import rwsc_pkg::*;
;
    localparam int S_CNT = 20;
    localparam int W_CNT = 50;
    localparam int H_CNT = 10;
    localparam int F_CNT = 8;
    localparam int L_CNT = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic vcc_lvt = 1'b0;
    logic vcc_bor = 1'b0;
    logic dm_line = 1'b1;
    logic osc_stable = 1'b1;
    logic wake_pend = 1'b0;
    logic insn_done = 1'b0;
    rwsc_core_ctl_t core_ctl;
    rwsc_clk_ctl_t clk_ctl;
    logic [15:0] fetch_addr;
    logic [7:0] program_stack_pointer;
    logic [7:0] dsp;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] rd;
    int n;

    rwsc_ctrl #(.SETTLE_CNT(CNT_W'(S_CNT)), .WDOG_CNT(CNT_W'(W_CNT)), .WDR_HOLD_CNT(CNT_W'(H_CNT)),
        .EXT_FAST_CNT(CNT_W'(F_CNT)), .EXT_SLOW_CNT(CNT_W'(L_CNT))) dut (
        .CLK(clk), .RST(rst), .CE(ce), .IO_WR(io_wr), .IO_RD(io_rd), .IO_ADDR(io_addr),
        .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .VCC_BELOW_LVT(vcc_lvt), .VCC_BELOW_BOR(vcc_bor),
        .DATA_MINUS_LINE(dm_line), .OSC_STABLE(osc_stable), .WAKE_INT_PEND(wake_pend),
        .INSN_DONE(insn_done), .CORE_CTL(core_ctl), .CLK_CTL(clk_ctl), .FETCH_ADDR(fetch_addr),
        .PROG_STACK_PTR(program_stack_pointer), .DATA_STACK_PTR(dsp));

    initial begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("[ERR] %0t run did not finish", $time);
            report_and_stop();
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] mask, input logic [7:0] exp, input string what);
        total_checks++;
        if ((got & mask) !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got & mask, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
        total_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("[ERR] %0t %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge clk);
        io_wr = 1'b0;
    endtask

    task automatic io_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        io_rd = 1'b1;
        io_addr = a;
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
    endtask

    task automatic wait_hold(input logic v, input int max, output int cnt);
        cnt = 0;
        while (core_ctl.hold !== v && cnt < max) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        chk_bit(core_ctl.chip_reset, 1'b1, "reset active");
        chk_bit(core_ctl.pins_hiz, 1'b1, "pins float");
        chk_bit(core_ctl.int_disable & core_ctl.usb_disable, 1'b1, "int usb off");
        chk_bit(core_ctl.ptr_clear, 1'b1, "pointer clear");
        chk_byte(program_stack_pointer | dsp, 8'hFF, STACK_PTR_RST, "stack pointers");
        chk_bit(1'(fetch_addr === FETCH_ADDR_RST), 1'b1, "fetch address");
        chk_bit(clk_ctl.lvr_on & clk_ctl.int_osc_on, 1'b1, "lvr and int osc");
        @(negedge clk);
        rst = 1'b0;
        wait_hold(1'b0, S_CNT + 20, n);
        chk_cnt(n, S_CNT, S_CNT + 6, "power-up settle");
        chk_bit(core_ctl.pc_load, 1'b1, "pc load");
        chk_bit(core_ctl.pc_push, 1'b0, "no push");
        io_read(ADDR_STATUS, rd);
        chk_byte(rd, 8'hFF, STATUS_RST, "status reset");
        io_read(ADDR_CLK_CFG, rd);
        chk_byte(rd, 8'hFF, CLK_CFG_RST, "cfg reset");
        io_read(ADDR_WDOG_CLEAR, rd);
        chk_byte(rd, 8'hFF, 8'h00, "write-only read");
        io_read(8'h30, rd);
        chk_byte(rd, 8'hFF, 8'h00, "unmapped read");
    endtask

    task automatic t_watchdog();
        io_write(ADDR_CLK_CFG, 8'h01);
        idle(2);
        wait_hold(1'b0, 40, n);
        chk_bit(clk_ctl.ext_mode, 1'b1, "ext mode on");
        chk_bit(clk_ctl.ext_osc_on & clk_ctl.wdog_on & ~clk_ctl.int_osc_on, 1'b1, "ext osc runs");
        repeat (4) begin
            idle(W_CNT - 10);
            io_write(ADDR_WDOG_CLEAR, 8'hA5);
            chk_bit(core_ctl.hold, 1'b0, "cleared watchdog");
        end
        ce = 1'b0;
        idle(W_CNT + 10);
        chk_bit(core_ctl.hold, 1'b0, "frozen watchdog");
        ce = 1'b1;
        wait_hold(1'b1, W_CNT + 10, n);
        chk_cnt(n, W_CNT - 3, W_CNT + 3, "watchdog period");
        chk_bit(core_ctl.chip_reset, 1'b1, "watchdog reset");
        chk_bit(clk_ctl.ext_mode, 1'b1, "mode kept");
        wait_hold(1'b0, H_CNT + 10, n);
        chk_cnt(n, H_CNT - 1, H_CNT + 2, "watchdog hold");
        chk_bit(core_ctl.pc_load, 1'b1, "restart at zero");
        io_read(ADDR_STATUS, rd);
        chk_byte(rd, ST_CAUSE_MASK, 8'h50, "cause bits");
        io_read(ADDR_CLK_CFG, rd);
        chk_byte(rd, 8'hFF, 8'h00, "cfg cleared");
    endtask

    task automatic t_suspend();
        logic [7:0] cfg;
        io_write(ADDR_STATUS, 8'h09);
        @(negedge clk);
        chk_bit(core_ctl.hold, 1'b1, "suspended");
        chk_bit(clk_ctl.int_osc_on | clk_ctl.ext_osc_on | clk_ctl.wdog_on, 1'b0, "osc off");
        chk_bit(clk_ctl.lvr_on, 1'b0, "lvr off");
        vcc_lvt = 1'b1;
        idle(8);
        chk_bit(core_ctl.chip_reset, 1'b0, "no lvr in suspend");
        vcc_lvt = 1'b0;
        idle(4);
        wake_pend = 1'b1;
        wait_hold(1'b0, 900, n);
        wake_pend = 1'b0;
        chk_cnt(n, INT_RESUME_CYC, INT_RESUME_CYC + 8, "internal resume");
        chk_bit(clk_ctl.ext_mode, 1'b0, "internal after wake");
        chk_bit(clk_ctl.lvr_on & clk_ctl.int_osc_on, 1'b1, "lvr back");
        chk_bit(core_ctl.int_defer, 1'b1, "defer");
        idle(3);
        chk_bit(core_ctl.int_defer, 1'b1, "defer held");
        insn_done = 1'b1;
        @(negedge clk);
        insn_done = 1'b0;
        chk_bit(core_ctl.int_defer, 1'b0, "defer done");
        io_read(ADDR_STATUS, rd);
        chk_byte(rd, 8'h08, 8'h00, "suspend bit clear");
        for (int i = 0; i < 2; i++) begin
            cfg = (i == 0) ? 8'h81 : 8'h01;
            io_write(ADDR_CLK_CFG, cfg);
            idle(2);
            wait_hold(1'b0, 40, n);
            dm_line = 1'b0;
            osc_stable = (i == 0);
            io_write(ADDR_STATUS, 8'h09);
            @(negedge clk);
            chk_bit(core_ctl.hold, 1'b1, "suspend with wake");
            if (i == 1) begin
                idle(6);
                chk_bit(core_ctl.hold, 1'b1, "osc not stable");
            end
            osc_stable = 1'b1;
            wait_hold(1'b0, 60, n);
            dm_line = 1'b1;
            chk_cnt(n, (i == 0) ? L_CNT : F_CNT, ((i == 0) ? L_CNT : F_CNT) + 8, "ext resume");
            chk_bit(clk_ctl.ext_mode, 1'b1, "ext after wake");
        end
    endtask

    task automatic t_lvr();
        io_write(ADDR_CLK_CFG, 8'h09);
        idle(2);
        chk_bit(clk_ctl.lvr_on, 1'b0, "lvr disabled");
        chk_bit(clk_ctl.bor_on, 1'b1, "bor armed");
        vcc_lvt = 1'b1;
        idle(8);
        chk_bit(core_ctl.hold, 1'b0, "lvr ignored");
        vcc_lvt = 1'b0;
        idle(4);
        io_write(ADDR_CLK_CFG, 8'h01);
        io_write(ADDR_STATUS, 8'h01);
        chk_bit(clk_ctl.lvr_on, 1'b1, "lvr enabled");
        vcc_lvt = 1'b1;
        idle(4);
        repeat (20) begin
            @(negedge clk);
            chk_bit(core_ctl.chip_reset, 1'b1, "lvr holds");
        end
        chk_bit(clk_ctl.ext_mode | clk_ctl.ext_osc_on, 1'b0, "back to internal");
        chk_bit(clk_ctl.int_osc_on, 1'b1, "int osc");
        vcc_lvt = 1'b0;
        wait_hold(1'b0, S_CNT + 20, n);
        chk_cnt(n, S_CNT, S_CNT + 6, "lvr settle");
        io_read(ADDR_STATUS, rd);
        chk_byte(rd, ST_LVBOR_MASK, 8'h10, "lvr cause");
    endtask

    task automatic t_refuse();
        io_write(ADDR_STATUS, 8'h08);
        wake_pend = 1'b1;
        idle(200);
        chk_bit(core_ctl.hold, 1'b1, "no run no wake");
        chk_bit(core_ctl.chip_reset, 1'b0, "still suspended");
        vcc_bor = 1'b1;
        idle(10);
        chk_bit(core_ctl.chip_reset, 1'b1, "bor in suspend");
        vcc_bor = 1'b0;
        wait_hold(1'b0, S_CNT + 20, n);
        wake_pend = 1'b0;
        chk_cnt(n, S_CNT, S_CNT + 6, "bor settle");
        chk_bit(core_ctl.pc_load, 1'b1, "bor restart");
        io_read(ADDR_STATUS, rd);
        chk_byte(rd, 8'h11, 8'h11, "bor cause");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        idle(10);
        t_power_up();
        t_watchdog();
        t_suspend();
        t_lvr();
        t_refuse();
        report_and_stop();
    end
endmodule // tb_rwsc_ctrl
